// File: core/dba_pkg.sv
package dba_pkg;
  // Register select codes on the register port.
  localparam logic SEL_CONTROL = 1'h0;
  localparam logic SEL_STATUS = 1'h1;
  // Control register field positions.
  localparam int CTL_INIT_BIT = 0;
  localparam int CTL_ABORT_BIT = 1;
  localparam int CTL_IE_BIT = 2;
  localparam int CTL_MAINT_BIT = 3;
  // Status register field positions.
  localparam int STS_BUSY_BIT = 31;
  localparam int STS_NORESP_BIT = 30;
  localparam int STS_CRD_BIT = 29;
  localparam int STS_PGE_BIT = 19;
  localparam int STS_NED_BIT = 18;
  localparam int STS_ATTENTION_FLAG_BIT = 16;
  // Reset values.
  localparam logic IE_RESET = 1'h1;
  localparam logic MAINT_RESET = 1'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
  // Timing.
  localparam int CLK_PERIOD_NS = 20;
  localparam int ACK_TIMEOUT_NS = 1500;
  localparam int ACK_TIMEOUT_CYCLES = (ACK_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACK_TIMER_W = 8;

  typedef enum logic [1:0] {
    ABT_IDLE = 2'b00,
    ABT_WAIT_EOB = 2'b01,
    ABT_DONE = 2'b10
  } dba_abort_e;

  // Same-clock events from the rest of the adapter.
  typedef struct packed {
    logic xfer_cmd;
    logic xfer_cmd_bad;
    logic load_param;
    logic no_resp;
    logic crd_data;
    logic xfer_end;
  } dba_event_s;

  // Lines driven toward the drive bus.
  typedef struct packed {
    logic run;
    logic demand_line;
    logic exception_line;
    logic fail;
    logic init;
  } dba_drive_s;
endpackage

// File: core/dba_sync.sv
module dba_sync #(
  parameter int W = 3
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // Data.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  always_comb begin
    meta_next = ce_in ? async_in : meta_reg;
    sync_next = ce_in ? meta_reg : sync_reg;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule

// File: core/dba_ack_timer.sv
module dba_ack_timer #(
  parameter int W = 8,
  parameter logic [W-1:0] LIMIT = 8'h4B
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // Control.
  input wire logic run_in,
  output logic expired_out
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic fire_reg;
  logic fire_next;

  // The count saturates at the limit so one wait fires only once.
  always_comb begin
    cnt_next = cnt_reg;
    fire_next = fire_reg;
    if (ce_in) begin
      fire_next = run_in && (cnt_reg == LIMIT - 1'b1);
      if (!run_in) begin
        cnt_next = '0;
      end else if (cnt_reg != LIMIT) begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_reg <= '0;
      fire_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      fire_reg <= fire_next;
    end
  end

  assign expired_out = fire_reg;
endmodule

// File: core/dba_ctrl_status.sv
// Summary of operation
// [RQ1] Control bits 31 to 4 always read zero.
// [RQ2] Control bit 3 puts the adapter into maintenance mode.
// [RQ3] Maintenance mode blocks run and demand and asserts fail.
// [RQ4] Maintenance mode cannot be set while a transfer is busy.
// [RQ5] Interrupt enable set by write or power-up, cleared by write zero or init.
// [RQ6] Abort bit starts abort; cleared by write zero, init or bus_a.
// [RQ7] Abort negates run, asserts exception, reads one after end-of-block falls.
// [RQ8] Init clears abort, enable and status; reads as zero.
// [RQ9] Init cancels pending commands, aborts transfer, drives bus init.
// [RQ10] Init interrupts when the enable bit was one.
// [RQ11] Status interrupts wait until no transfer is active.
// [RQ12] Busy bit is read-only, set on command, cleared on abort.
// [RQ13] No-response sets bit 30 and retries; write one or init clears.
// [RQ14] Corrected read data sets bit 29; write one or init clears.
// [RQ15] Programming errors set bit 19; write one clears; interrupts.
// [RQ16] No acknowledge within 1.5 us of demand sets bit 18, zero data.
// [RQ17] All control bits read back except init; the abort bit reads one only in the done state.
// [RQ18] Attention line sets the attention bit, which interrupts.
// [RQ19] Writing zero keeps flags; status bits 28 to 20 read zero.
// [RQ20] Software checks busy before loading parameters or maintenance mode.
module dba_ctrl_status (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // Register port.
  input wire logic reg_sel_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  // Adapter events and requests.
  input wire dba_pkg::dba_event_s event_in,
  input wire logic run_req_in,
  input wire logic demand_req_in,
  input wire logic bus_a_in,
  // Drive bus pins.
  input wire logic attention_line_in,
  input wire logic end_of_block_line_in,
  input wire logic xfer_ack_line_in,
  output dba_pkg::dba_drive_s drive_out,
  // Adapter side outputs.
  output logic abort_active_out,
  output logic retry_out,
  output logic zero_read_data_out,
  output logic irq_out
);
  logic [2:0] pins_sync;
  logic attention_flag_s;
  logic eob_s;
  logic ack_s;
  logic ack_expired;
  logic wr_ctl;
  logic wr_sts;
  logic init_wr;
  logic eob_fall;
  logic cmd_ok;

  logic maint_reg, maint_next;
  logic ie_reg, ie_next;
  dba_pkg::dba_abort_e abt_reg, abt_next;
  logic busy_reg, busy_next;
  logic noresp_reg, noresp_next;
  logic crd_reg, crd_next;
  logic pge_reg, pge_next;
  logic ned_reg, ned_next;
  logic attention_flag_reg, attention_flag_next;
  logic init_irq_reg, init_irq_next;
  logic irq_reg, irq_next;
  logic retry_reg, retry_next;
  logic zero_rd_reg, zero_rd_next;
  logic abort_act_reg, abort_act_next;
  logic eob_d_reg, eob_d_next;
  logic [31:0] rdata_reg, rdata_next;
  dba_pkg::dba_drive_s drive_reg, drive_next;

  // Drive bus lines come from another clock's world and are synchronised first.
  dba_sync #(
    .W(3)
  ) u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .async_in({attention_line_in, end_of_block_line_in, xfer_ack_line_in}),
    .sync_out(pins_sync)
  );

  assign attention_flag_s = pins_sync[2];
  assign eob_s = pins_sync[1];
  assign ack_s = pins_sync[0];

  dba_ack_timer #(
    .W(dba_pkg::ACK_TIMER_W),
    .LIMIT(dba_pkg::ACK_TIMER_W'(dba_pkg::ACK_TIMEOUT_CYCLES))
  ) u_timer (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .run_in(drive_reg.demand_line && !ack_s),
    .expired_out(ack_expired)
  );

  function automatic logic w1c(input logic flag, input logic set, input logic clr);
    // A set arriving with the clear wins, so no event is lost.
    w1c = set | (flag & ~clr);
  endfunction

  always_comb begin
    wr_ctl = reg_wr_in && (reg_sel_in == dba_pkg::SEL_CONTROL);
    wr_sts = reg_wr_in && (reg_sel_in == dba_pkg::SEL_STATUS);
    init_wr = wr_ctl && reg_wdata_in[dba_pkg::CTL_INIT_BIT];
    eob_fall = eob_d_reg && !eob_s;
    cmd_ok = event_in.xfer_cmd && !busy_reg && !event_in.xfer_cmd_bad;
  end

  always_comb begin
    maint_next = maint_reg;
    ie_next = ie_reg;
    abt_next = abt_reg;
    busy_next = busy_reg;
    noresp_next = noresp_reg;
    crd_next = crd_reg;
    pge_next = pge_reg;
    ned_next = ned_reg;
    attention_flag_next = attention_flag_reg;
    init_irq_next = init_irq_reg;
    irq_next = irq_reg;
    retry_next = retry_reg;
    zero_rd_next = zero_rd_reg;
    abort_act_next = abort_act_reg;
    eob_d_next = eob_d_reg;
    rdata_next = rdata_reg;
    drive_next = drive_reg;
    if (ce_in) begin
      eob_d_next = eob_s;
      if (wr_ctl) begin
        // Maintenance mode only turns on with no transfer running.
        maint_next = reg_wdata_in[dba_pkg::CTL_MAINT_BIT] && (!busy_reg || maint_reg); // [RQ2] [RQ4]
        ie_next = reg_wdata_in[dba_pkg::CTL_IE_BIT]; // [RQ5] [RQ17]
      end
      if (init_wr) begin
        ie_next = 1'b0; // [RQ5] [RQ8]
      end
      case (abt_reg)
        dba_pkg::ABT_IDLE: begin
          if (wr_ctl && reg_wdata_in[dba_pkg::CTL_ABORT_BIT]) begin
            abt_next = dba_pkg::ABT_WAIT_EOB; // [RQ6]
          end
        end
        dba_pkg::ABT_WAIT_EOB: begin
          if (eob_fall) begin
            abt_next = dba_pkg::ABT_DONE; // [RQ7]
          end
        end
        dba_pkg::ABT_DONE: begin
          abt_next = dba_pkg::ABT_DONE;
        end
        default: begin
          abt_next = dba_pkg::ABT_IDLE;
        end
      endcase
      if (init_wr || bus_a_in || (wr_ctl && !reg_wdata_in[dba_pkg::CTL_ABORT_BIT])) begin
        abt_next = dba_pkg::ABT_IDLE; // [RQ6] [RQ8]
      end
      // Busy ends with a finished or aborted transfer; init aborts it too.
      if (init_wr || event_in.xfer_end || (abt_reg == dba_pkg::ABT_WAIT_EOB && eob_fall)) begin
        busy_next = 1'b0; // [RQ9] [RQ12]
      end
      if (cmd_ok && !init_wr) begin
        busy_next = 1'b1; // [RQ12]
      end
      noresp_next = w1c(noresp_reg, event_in.no_resp,
                        init_wr || (wr_sts && reg_wdata_in[dba_pkg::STS_NORESP_BIT])); // [RQ13]
      crd_next = w1c(crd_reg, event_in.crd_data,
                     init_wr || (wr_sts && reg_wdata_in[dba_pkg::STS_CRD_BIT])); // [RQ14]
      pge_next = w1c(pge_reg,
                     (event_in.xfer_cmd && busy_reg) || event_in.xfer_cmd_bad ||
                     (event_in.load_param && busy_reg) ||
                     (wr_ctl && reg_wdata_in[dba_pkg::CTL_MAINT_BIT] && busy_reg),
                     init_wr || (wr_sts && reg_wdata_in[dba_pkg::STS_PGE_BIT])); // [RQ15] [RQ19]
      ned_next = w1c(ned_reg, ack_expired,
                     init_wr || (wr_sts && reg_wdata_in[dba_pkg::STS_NED_BIT])); // [RQ16] [RQ19]
      attention_flag_next = w1c(attention_flag_reg, attention_flag_s,
                      init_wr || (wr_sts && reg_wdata_in[dba_pkg::STS_ATTENTION_FLAG_BIT])); // [RQ18]
      // The enable is sampled before init clears it; reading control acknowledges.
      init_irq_next = w1c(init_irq_reg, init_wr && ie_reg,
                          reg_rd_in && (reg_sel_in == dba_pkg::SEL_CONTROL)); // [RQ10]
      irq_next = init_irq_reg ||
                 (ie_reg && (pge_reg || ned_reg || attention_flag_reg) && !busy_reg); // [RQ11] [RQ15]
      retry_next = event_in.no_resp; // [RQ13]
      zero_rd_next = ack_expired; // [RQ16]
      abort_act_next = (abt_next != dba_pkg::ABT_IDLE) || init_wr; // [RQ6] [RQ9]
      drive_next.run = run_req_in && !maint_next && (abt_next == dba_pkg::ABT_IDLE) &&
                       !init_wr; // [RQ3] [RQ7]
      drive_next.demand_line = demand_req_in && !maint_next; // [RQ3]
      drive_next.exception_line = (abt_next == dba_pkg::ABT_WAIT_EOB); // [RQ7]
      drive_next.fail = maint_next; // [RQ3]
      drive_next.init = init_wr; // [RQ9]
      if (reg_rd_in) begin
        rdata_next = '0; // [RQ1] [RQ19]
        if (reg_sel_in == dba_pkg::SEL_CONTROL) begin
          rdata_next[dba_pkg::CTL_MAINT_BIT] = maint_reg; // [RQ17]
          rdata_next[dba_pkg::CTL_IE_BIT] = ie_reg;
          rdata_next[dba_pkg::CTL_ABORT_BIT] = (abt_reg == dba_pkg::ABT_DONE); // [RQ7]
        end else begin
          rdata_next[dba_pkg::STS_BUSY_BIT] = busy_reg;
          rdata_next[dba_pkg::STS_NORESP_BIT] = noresp_reg;
          rdata_next[dba_pkg::STS_CRD_BIT] = crd_reg;
          rdata_next[dba_pkg::STS_PGE_BIT] = pge_reg;
          rdata_next[dba_pkg::STS_NED_BIT] = ned_reg;
          rdata_next[dba_pkg::STS_ATTENTION_FLAG_BIT] = attention_flag_reg;
        end
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      maint_reg <= dba_pkg::MAINT_RESET;
      ie_reg <= dba_pkg::IE_RESET; // [RQ5]
      abt_reg <= dba_pkg::ABT_IDLE;
      busy_reg <= 1'b0;
      noresp_reg <= 1'b0;
      crd_reg <= 1'b0;
      pge_reg <= 1'b0;
      ned_reg <= 1'b0;
      attention_flag_reg <= 1'b0;
      init_irq_reg <= 1'b0;
      irq_reg <= 1'b0;
      retry_reg <= 1'b0;
      zero_rd_reg <= 1'b0;
      abort_act_reg <= 1'b0;
      eob_d_reg <= 1'b0;
      rdata_reg <= dba_pkg::RDATA_RESET;
      drive_reg <= '0;
    end else begin
      maint_reg <= maint_next;
      ie_reg <= ie_next;
      abt_reg <= abt_next;
      busy_reg <= busy_next;
      noresp_reg <= noresp_next;
      crd_reg <= crd_next;
      pge_reg <= pge_next;
      ned_reg <= ned_next;
      attention_flag_reg <= attention_flag_next;
      init_irq_reg <= init_irq_next;
      irq_reg <= irq_next;
      retry_reg <= retry_next;
      zero_rd_reg <= zero_rd_next;
      abort_act_reg <= abort_act_next;
      eob_d_reg <= eob_d_next;
      rdata_reg <= rdata_next;
      drive_reg <= drive_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign drive_out = drive_reg;
  assign abort_active_out = abort_act_reg;
  assign retry_out = retry_reg;
  assign zero_read_data_out = zero_rd_reg;
  assign irq_out = irq_reg;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_abort_req;
    ce_in && wr_ctl && reg_wdata_in[dba_pkg::CTL_ABORT_BIT] && !init_wr && !bus_a_in &&
      abt_reg == dba_pkg::ABT_IDLE;
  endsequence

  sequence s_abort_wait;
    ##1 drive_out.exception_line && !drive_out.run;
  endsequence

  chk_ctl_upper_zero: assert property ( // [RQ1]
    ce_in && reg_rd_in && reg_sel_in == dba_pkg::SEL_CONTROL |=>
      reg_rdata_out[31:4] == 28'h0 && !reg_rdata_out[0])
    else $error("Control readback has nonzero reserved or init bits.");

  // The drive lines load from the same next value as the mode bit, so they agree in one cycle.
  chk_maint_lines: assert property ( // [RQ3]
    maint_reg |-> drive_out.fail && !drive_out.run && !drive_out.demand_line)
    else $error("Maintenance mode did not detach the drive bus.");

  chk_maint_blocked: assert property ( // [RQ4]
    ce_in && busy_reg && !maint_reg |=> !maint_reg)
    else $error("Maintenance mode was set during a transfer.");

  chk_abort_lines: assert property ( // [RQ7]
    s_abort_req |-> s_abort_wait)
    else $error("Abort did not drop run and raise exception.");

  chk_abort_done: assert property ( // [RQ7]
    ce_in && abt_reg == dba_pkg::ABT_WAIT_EOB && eob_fall && !init_wr && !bus_a_in &&
      !wr_ctl |=> abt_reg == dba_pkg::ABT_DONE && !busy_reg)
    else $error("Abort did not complete on the end-of-block trailing edge.");

  chk_init_effects: assert property ( // [RQ8] [RQ9]
    ce_in && init_wr |=> drive_out.init && !ie_reg && !pge_reg && !busy_reg &&
      abort_active_out && abt_reg == dba_pkg::ABT_IDLE)
    else $error("Init did not clear state or drive the bus init line.");

  chk_init_irq: assert property ( // [RQ10]
    ce_in && init_wr && ie_reg |=> ##1 irq_out)
    else $error("Init with interrupts enabled raised no interrupt.");

  chk_irq_defer: assert property ( // [RQ11]
    busy_reg && !init_irq_reg && ce_in |=> !irq_out)
    else $error("Status interrupt was raised during a transfer.");

  chk_busy_set: assert property ( // [RQ12]
    ce_in && cmd_ok && !init_wr |=> busy_reg)
    else $error("Accepted transfer command did not set busy.");

  chk_noresp_flag: assert property ( // [RQ13]
    ce_in && event_in.no_resp |=> noresp_reg && retry_out)
    else $error("No-response confirmation not flagged or retried.");

  chk_ned_timeout: assert property ( // [RQ16]
    ce_in && ack_expired |=> ned_reg && zero_read_data_out)
    else $error("Acknowledge timeout not flagged.");
endmodule

// File: dv/dba_drive_model.sv
module dba_drive_model (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Behaviour select: high answers demand promptly, low never answers.
  input wire logic ack_en_in,
  // Drive bus lines.
  input wire dba_pkg::dba_drive_s drive_in,
  output logic xfer_ack_line_out,
  output logic end_of_block_line_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] dem_q;
  logic exc_q;
  logic [2:0] eob_cnt;
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dem_q <= 2'h0;
      exc_q <= 1'h0;
      eob_cnt <= 3'h0;
    end else begin
      dem_q <= {dem_q[0], drive_in.demand_line};
      exc_q <= drive_in.exception_line;
      if (drive_in.exception_line && !exc_q) begin
        eob_cnt <= 3'h4;
      end else if (eob_cnt != 3'h0) begin
        eob_cnt <= eob_cnt - 3'h1;
      end
    end
  end
  // Acknowledge drops as soon as demand goes, so a stale answer never lingers.
  assign xfer_ack_line_out = ack_en_in && dem_q[1] && drive_in.demand_line;
  assign end_of_block_line_out = (eob_cnt != 3'h0);
endmodule

// File: dv/test_drive_bus_adapter_ctrl_status.sv
module test_drive_bus_adapter_ctrl_status;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic ce_in = 1'h1;
  logic sel = 1'h0;
  logic wr = 1'h0;
  logic rd = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  dba_pkg::dba_event_s ev_r = '0;
  logic run_req = 1'h0;
  logic demand_req = 1'h0;
  logic bus_a = 1'h0;
  logic attention = 1'h0;
  logic ack_en = 1'h1;
  logic eob;
  logic ack;
  dba_pkg::dba_drive_s drv;
  logic abort_act;
  logic retry;
  logic zero_rd;
  logic irq;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int retry_cnt = 0;
  int zero_cnt = 0;

  dba_ctrl_status DUT (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .reg_sel_in(sel), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .event_in(ev_r), .run_req_in(run_req),
    .demand_req_in(demand_req), .bus_a_in(bus_a), .attention_line_in(attention),
    .end_of_block_line_in(eob), .xfer_ack_line_in(ack), .drive_out(drv),
    .abort_active_out(abort_act), .retry_out(retry), .zero_read_data_out(zero_rd),
    .irq_out(irq)
  );

  dba_drive_model drive_far (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .ack_en_in(ack_en),
    .drive_in(drv), .xfer_ack_line_out(ack), .end_of_block_line_out(eob)
  );

  initial begin
    forever #10 clk_in = ~clk_in;
  end

  // Pulses are counted rather than sampled, so their exact cycle cannot be missed.
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    retry_cnt <= retry_cnt + int'(retry === 1'h1);
    zero_cnt <= zero_cnt + int'(zero_rd === 1'h1);
    if (cycles == 4000) begin
      failures = failures + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      failures = failures + 1;
    end
  endtask

  task automatic wreg(input logic s, input logic [31:0] d);
    @(posedge clk_in);
    sel <= s;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk_in);
    wr <= 1'h0;
    #1;
  endtask

  task automatic rchk(input logic s, input logic [31:0] exp);
    @(posedge clk_in);
    sel <= s;
    rd <= 1'h1;
    @(posedge clk_in);
    rd <= 1'h0;
    #1;
    chk(s ? "status" : "control", exp, rdata);
  endtask

  task automatic ev(input logic [5:0] m);
    @(posedge clk_in);
    ev_r <= m;
    @(posedge clk_in);
    ev_r <= '0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  initial begin
    idle(2);
    reset_n_in <= 1'h1;
    rchk(1'h1, 32'h0);
    rchk(1'h0, 32'h4);
    run_req <= 1'h1;
    demand_req <= 1'h1;
    wreg(1'h0, 32'hFFFF_FFF8);
    rchk(1'h0, 32'h8);
    idle(2);
    chk("drive", 32'h2, {27'h0, drv});
    wreg(1'h0, 32'h0);
    demand_req <= 1'h0;
    rchk(1'h0, 32'h0);
    idle(2);
    chk("drive", 32'h10, {27'h0, drv});
    demand_req <= 1'h1;
    idle(100);
    demand_req <= 1'h0;
    rchk(1'h1, 32'h0);
    ev(6'h20);
    rchk(1'h1, 32'h8000_0000);
    wreg(1'h1, 32'h8000_0000);
    rchk(1'h1, 32'h8000_0000);
    wreg(1'h0, 32'h8);
    rchk(1'h0, 32'h0);
    rchk(1'h1, 32'h8008_0000);
    wreg(1'h0, 32'h2);
    chk("drive", 32'h4, {27'h0, drv});
    chk("abort", 32'h1, {31'h0, abort_act});
    rchk(1'h0, 32'h0);
    for (int i = 0; i < 30 && drv.exception_line !== 1'h0; i++) idle(1);
    rchk(1'h0, 32'h2);
    rchk(1'h1, 32'h0008_0000);
    wreg(1'h0, 32'h0);
    rchk(1'h0, 32'h0);
    wreg(1'h1, 32'hFFFF_FFFF);
    rchk(1'h1, 32'h0);
    ev(6'h04);
    ev(6'h02);
    idle(3);
    chk("retry", 32'h1, retry_cnt);
    rchk(1'h1, 32'h6000_0000);
    wreg(1'h1, 32'h0);
    rchk(1'h1, 32'h6000_0000);
    wreg(1'h1, 32'h6000_0000);
    rchk(1'h1, 32'h0);
    wreg(1'h0, 32'h4);
    ack_en <= 1'h0;
    demand_req <= 1'h1;
    idle(70);
    chk("zero data", 32'h0, zero_cnt);
    idle(20);
    chk("zero data", 32'h1, zero_cnt);
    chk("irq", 32'h1, {31'h0, irq});
    demand_req <= 1'h0;
    ack_en <= 1'h1;
    rchk(1'h1, 32'h0004_0000);
    wreg(1'h1, 32'h0004_0000);
    rchk(1'h1, 32'h0);
    ev(6'h20);
    ev(6'h08);
    idle(3);
    chk("irq", 32'h0, {31'h0, irq});
    ev(6'h01);
    idle(3);
    chk("irq", 32'h1, {31'h0, irq});
    wreg(1'h1, 32'h0008_0000);
    ev(6'h10);
    idle(3);
    chk("irq", 32'h1, {31'h0, irq});
    wreg(1'h1, 32'h0008_0000);
    idle(2);
    chk("irq", 32'h0, {31'h0, irq});
    attention <= 1'h1;
    idle(4);
    rchk(1'h1, 32'h0001_0000);
    chk("irq", 32'h1, {31'h0, irq});
    attention <= 1'h0;
    idle(3);
    wreg(1'h1, 32'h0001_0000);
    ev(6'h20);
    ev(6'h02);
    wreg(1'h0, 32'h1);
    chk("init", 32'h1, {31'h0, drv.init});
    chk("abort", 32'h1, {31'h0, abort_act});
    idle(1);
    chk("irq", 32'h1, {31'h0, irq});
    rchk(1'h0, 32'h0);
    rchk(1'h1, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wreg(1'h0, 32'h2);
    @(posedge clk_in);
    bus_a <= 1'h1;
    @(posedge clk_in);
    bus_a <= 1'h0;
    idle(2);
    chk("abort", 32'h0, {31'h0, abort_act});
    end_of_test();
  end
endmodule
